// ==== common/pbss_consts.vh ====
`ifndef PBSS_CONSTS_VH
`define PBSS_CONSTS_VH

// ****************************************
// Array geometry
// ****************************************
`define PBSS_ADDR_W 16
`define PBSS_DEPTH 65536
`define PBSS_DATA_W 32
`define PBSS_LANES 4
`define PBSS_LANE_W 8

// ****************************************
// Field positions
// ****************************************
`define PBSS_LOW_HI 1
`define PBSS_LOW_LO 0
`define PBSS_UPPER_LO 2

// ****************************************
// Reset values and lane masks
// ****************************************
`define PBSS_RST_STROBE_N 1'b1
`define PBSS_RST_CE_FIRST_N 1'b1
`define PBSS_RST_CE_SECOND 1'b0
`define PBSS_RST_CE_THIRD_N 1'b1
`define PBSS_RST_WRITE_N 1'b1
`define PBSS_RST_LANES_N 4'hf
`define PBSS_RST_BEAT 2'h0
`define PBSS_ALL_LANES 4'hf
`define PBSS_NO_LANES 4'h0

`endif

// ==== sim/pbss_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checker
// ****************************************
module pbss_checker #(
  parameter LANES = 4,
  parameter LANE_W = 8
) (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic PROCESSOR_ADDR_STROBE_N_I,
  input wire logic CONTROLLER_ADDR_STROBE_N_I,
  input wire logic CHIP_SELECT_FIRST_N_I,
  input wire logic CHIP_SELECT_SECOND_I,
  input wire logic CHIP_SELECT_THIRD_N_I,
  input wire logic [LANES-1:0] BYTE_LANE_WRITE_SELECT_N_I,
  input wire logic BYTE_WRITE_ENABLE_N_I,
  input wire logic GLOBAL_WRITE_N_I,
  input wire logic OUTPUT_ENABLE_N_I,
  input wire logic SLEEP_REQUEST_I,
  input wire logic [LANES*LANE_W-1:0] DQ_O,
  input wire logic DQ_OE_O
);
  wire sel = !CHIP_SELECT_FIRST_N_I && CHIP_SELECT_SECOND_I && !CHIP_SELECT_THIRD_N_I;
  wire rdop = GLOBAL_WRITE_N_I && (BYTE_WRITE_ENABLE_N_I || &BYTE_LANE_WRITE_SELECT_N_I);
  wire pst = !PROCESSOR_ADDR_STROBE_N_I && !CHIP_SELECT_FIRST_N_I;
  wire cst = !CONTROLLER_ADDR_STROBE_N_I && !pst;
  wire go = sel && !SLEEP_REQUEST_I;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  reset_quiet_a: assert property (disable iff (1'b0) SYS_RST_I |=> !DQ_OE_O && DQ_O == '0)
    else $error("output active after reset");
  oe_mask_a: assert property (OUTPUT_ENABLE_N_I |-> !DQ_OE_O)
    else $error("drive while output enable high");
  sleep_mask_a: assert property (SLEEP_REQUEST_I |-> !DQ_OE_O)
    else $error("drive while asleep");
  read_lat_a: assert property (pst && go && rdop ##1 !SLEEP_REQUEST_I [*2] |=>
    DQ_OE_O || OUTPUT_ENABLE_N_I || SLEEP_REQUEST_I) else $error("read data late");
  ctrl_lat_a: assert property (cst && go && rdop ##1 !SLEEP_REQUEST_I [*2] |=>
    DQ_OE_O || OUTPUT_ENABLE_N_I || SLEEP_REQUEST_I) else $error("ctrl read data late");
  desel_idle_a: assert property ((pst || cst) && !sel && !SLEEP_REQUEST_I |-> ##3 !DQ_OE_O)
    else $error("drive after deselect");
  dq_hold_a: assert property (!$stable(DQ_O) && !$past(SYS_RST_I) && !OUTPUT_ENABLE_N_I
    && !SLEEP_REQUEST_I |-> DQ_OE_O) else $error("data changed without read");
  start_gap_a: assert property ($fell(SYS_RST_I) |-> !DQ_OE_O [*3])
    else $error("drive too early after reset");
  cover property (pst && go && rdop);
  cover property (cst && go);
  cover property (SLEEP_REQUEST_I);
endmodule
bind pbss_top pbss_checker #(.LANES(LANES), .LANE_W(LANE_W)) u_pbss_checker (.*);
`default_nettype wire

// ==== sim/pbss_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Bus controller model
// ****************************************
module pbss_ctrl (
  input wire logic clk_i
);
  logic ps = 1'b1, cs = 1'b1, st = 1'b1, c1 = 1'b1, c2 = 1'b0, c3 = 1'b0;
  logic gw = 1'b1, be = 1'b1, oe = 1'b0, zz = 1'b0, md = 1'b1;
  logic [3:0] bw = 4'hf;
  logic [15:0] a = 16'h0;
  logic [31:0] d = 32'h0;
  task beat(input logic [4:0] k, input logic [15:0] ai, input logic [5:0] w,
    input logic [31:0] di);
    @(posedge clk_i);
    {ps, cs, st, c1, c2} <= k;
    a <= ai;
    {gw, be, bw} <= w;
    d <= (w == 6'h3f) ? ~d : di;
  endtask
endmodule
`default_nettype wire

// ==== sim/pbss_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module pbss_tb_top;
  localparam logic [4:0] SP = 5'b01101, SC = 5'b10101, ID = 5'b11101, ST = 5'b11001;
  localparam logic [5:0] RD = 6'h3f, GW = 6'h1f;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] dq;
  logic oe;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  logic [85:0] rows [5] = '{{16'h0010, 6'h1f, 32'haabbccdd, 32'haabbccdd},
    {16'h0011, 6'h00, 32'haabbccdd, 32'haabbccdd}, {16'h0012, 6'h2a, 32'haabbccdd, 32'h11bb33dd},
    {16'hffff, 6'h35, 32'haabbccdd, 32'h11223344}, {16'h0013, 6'h27, 32'haabbccdd, 32'haa223344}};
  always #20 clk = ~clk;
  pbss_ctrl u_pbss_ctrl (.clk_i(clk));
  pbss_top u_pbss_top (.CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(u_pbss_ctrl.a),
    .PROCESSOR_ADDR_STROBE_N_I(u_pbss_ctrl.ps), .CONTROLLER_ADDR_STROBE_N_I(u_pbss_ctrl.cs),
    .BURST_STEP_N_I(u_pbss_ctrl.st), .CHIP_SELECT_FIRST_N_I(u_pbss_ctrl.c1),
    .CHIP_SELECT_SECOND_I(u_pbss_ctrl.c2), .CHIP_SELECT_THIRD_N_I(u_pbss_ctrl.c3),
    .BYTE_LANE_WRITE_SELECT_N_I(u_pbss_ctrl.bw), .BYTE_WRITE_ENABLE_N_I(u_pbss_ctrl.be),
    .GLOBAL_WRITE_N_I(u_pbss_ctrl.gw), .OUTPUT_ENABLE_N_I(u_pbss_ctrl.oe),
    .SLEEP_REQUEST_I(u_pbss_ctrl.zz), .BURST_ORDER_INTERLEAVED_I(u_pbss_ctrl.md),
    .DQ_I(u_pbss_ctrl.d), .DQ_O(dq), .DQ_OE_O(oe));
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %0t %h %h", $time, s, e);
    end
  endtask
  task tally_and_finish;
    if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task bt(input logic [4:0] k, input logic [15:0] a, input logic [5:0] w, input logic [31:0] d);
    u_pbss_ctrl.beat(k, a, w, d);
  endtask
  task idle(input int n);
    repeat (n) bt(ID, 16'h0, RD, 32'h0);
  endtask
  task wr(input logic [15:0] a, input logic [5:0] w, input logic [31:0] d);
    bt(SP, a, w, d);
    idle(1);
  endtask
  task rd(input logic [4:0] k, input logic [15:0] a, input logic [31:0] e, input bit f);
    bt(k, a, RD, 32'h0);
    idle(2);
    #1;
    if (f) chk(oe, 1'b0);
    idle(1);
    #1;
    chk(dq, e);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 1000) begin
      fail_count++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(dq, 32'h0);
    chk(oe, 1'b0);
    foreach (rows[i]) begin
      wr(rows[i][85:70], GW, 32'h11223344);
      wr(rows[i][85:70], rows[i][69:64], rows[i][63:32]);
      rd(SP, rows[i][85:70], rows[i][31:0], 1'b0);
    end
    for (int m = 1; m >= 0; m--) begin
      @(posedge clk);
      rst <= 1'b1;
      u_pbss_ctrl.md <= m[0];
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 4; i++) wr({14'h0080, i[1:0]}, GW, {16'h5a5a, 14'h0080, i[1:0]});
      bt(SP, 16'h0201, RD, 32'h0);
      bt(ST, 16'h0, RD, 32'h0);
      bt(ST, 16'h0, RD, 32'h0);
      for (int i = 0; i < 4; i++) begin
        bt(i == 0 ? ST : ID, 16'h0, RD, 32'h0);
        #1;
        chk(dq, {16'h5a5a, 14'h0080, m[0] ? 2'(1 ^ i) : 2'(1 + i)});
      end
    end
    bt(5'b10100, 16'h0, RD, 32'h0);
    bt(5'b01111, 16'h0010, GW, 32'h0);
    bt(5'b01100, 16'h0010, GW, 32'h0);
    idle(1);
    rd(SC, 16'h0010, 32'haabbccdd, 1'b1);
    chk(oe, 1'b1);
    @(posedge clk);
    u_pbss_ctrl.oe <= 1'b1;
    #1;
    chk(oe, 1'b0);
    @(posedge clk);
    u_pbss_ctrl.oe <= 1'b0;
    u_pbss_ctrl.zz <= 1'b1;
    #1;
    chk(oe, 1'b0);
    @(posedge clk);
    u_pbss_ctrl.zz <= 1'b0;
    rd(SP, 16'h0010, 32'haabbccdd, 1'b0);
    tally_and_finish;
  end
endmodule
`default_nettype wire

// ==== verilog/pbss_burst.v ====
`timescale 1ns/1ps
`default_nettype none
`include "pbss_consts.vh"

// ****************************************
// Two-bit burst counter
// ****************************************
module pbss_burst (
  input wire clk_i,
  input wire rst_i,
  input wire load_i,
  input wire [1:0] load_val_i,
  input wire step_i,
  input wire interleaved_i,
  output wire [1:0] low_o
);

  reg [1:0] base;
  reg [1:0] beat;
  reg [1:0] next_beat;
  reg [1:0] next_base;

  always @* begin
    next_base = base;
    next_beat = beat;
    if (load_i) begin
      next_base = load_val_i;
      next_beat = `PBSS_RST_BEAT;
    end else if (step_i) begin
      next_beat = beat + 2'h1;
    end
  end

  // Sequence chosen by the order strap
  assign low_o = interleaved_i ? (next_base ^ next_beat) :
                 (next_base + next_beat);

  always @(posedge clk_i) begin
    if (rst_i) begin
      base <= `PBSS_RST_BEAT;
      beat <= `PBSS_RST_BEAT;
    end else begin
      base <= next_base;
      beat <= next_beat;
    end
  end

endmodule

`default_nettype wire

// ==== verilog/pbss_mem.v ====
`timescale 1ns/1ps
`default_nettype none
`include "pbss_consts.vh"

// ****************************************
// Word array with byte-lane writes
// ****************************************
module pbss_mem #(
  parameter ADDR_W = `PBSS_ADDR_W,
  parameter DEPTH = `PBSS_DEPTH,
  parameter LANES = `PBSS_LANES,
  parameter LANE_W = `PBSS_LANE_W
) (
  input wire clk_i,
  input wire wr_en_i,
  input wire [LANES-1:0] wr_lanes_i,
  input wire rd_en_i,
  input wire [ADDR_W-1:0] addr_i,
  input wire [LANES*LANE_W-1:0] wdata_i,
  output reg [LANES*LANE_W-1:0] rdata_o
);

  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : lane
      reg [LANE_W-1:0] cells [0:DEPTH-1];
      // Unselected lanes keep their byte
      always @(posedge clk_i) begin
        if (wr_en_i && wr_lanes_i[g]) begin
          cells[addr_i] <= wdata_i[g*LANE_W +: LANE_W];
        end
        if (rd_en_i) begin
          rdata_o[g*LANE_W +: LANE_W] <= cells[addr_i];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ==== verilog/pbss_top.v ====
`timescale 1ns/1ps
`default_nettype none
`include "pbss_consts.vh"

// Contract
// - Store 65,536 words of 32 bits; address selects one word.
// - Every synchronous input is captured in an input register on the rising edge.
// - Address and enables load only when a strobe is sampled low.
// - New address needs a strobe low and all three chip selects active.
// - Two low address bits load the two-bit burst counter.
// - Later burst addresses come from inside, stepped by the burst step input.
// - Counter steps when burst step sampled low, holds otherwise.
// - Interleaved or linear sequence chosen by a static input.
// - Address, data, write controls registered, array write finishes internally.
// - Write updates the selected byte lanes, leaves others unchanged.
// - Global write low writes all four lanes regardless of selects.
// - A lane select writes only with byte write enable active.
// - First chip select high makes the processor strobe ignored.
// - Selected only when first low, second high, third low.
// - Output enable and sleep act without clock sampling.
// - Read data pass through rising-edge output registers.
// - Four-word burst takes three cycles then one per word.
// - Order strap low gives linear, high gives interleaved; static.
// - Both strobes low with first chip select low: only the processor strobe acts.
// - Sleep high stops activity and keeps stored data.
// - First clock of a read after deselect keeps data pins undriven.
module pbss_top #(
  parameter ADDR_W = `PBSS_ADDR_W,
  parameter DEPTH = `PBSS_DEPTH,
  parameter LANES = `PBSS_LANES,
  parameter LANE_W = `PBSS_LANE_W
) (
  input wire CLK_I,
  input wire SYS_RST_I,
  input wire [ADDR_W-1:0] ADDR_I,
  input wire PROCESSOR_ADDR_STROBE_N_I,
  input wire CONTROLLER_ADDR_STROBE_N_I,
  input wire BURST_STEP_N_I,
  input wire CHIP_SELECT_FIRST_N_I,
  input wire CHIP_SELECT_SECOND_I,
  input wire CHIP_SELECT_THIRD_N_I,
  input wire [LANES-1:0] BYTE_LANE_WRITE_SELECT_N_I,
  input wire BYTE_WRITE_ENABLE_N_I,
  input wire GLOBAL_WRITE_N_I,
  input wire OUTPUT_ENABLE_N_I,
  input wire SLEEP_REQUEST_I,
  input wire BURST_ORDER_INTERLEAVED_I,
  input wire [LANES*LANE_W-1:0] DQ_I,
  output reg [LANES*LANE_W-1:0] DQ_O,
  output wire DQ_OE_O
);

  // ****************************************
  // Input registers
  // ****************************************
  reg [ADDR_W-1:0] in_addr;
  reg [LANES*LANE_W-1:0] in_data;
  reg in_proc_n;
  reg in_ctrl_n;
  reg in_step_n;
  reg in_ce_first_n;
  reg in_ce_second;
  reg in_ce_third_n;
  reg [LANES-1:0] in_lanes_n;
  reg in_bwe_n;
  reg in_gw_n;

  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      in_addr <= {ADDR_W{1'b0}};
      in_data <= {LANES*LANE_W{1'b0}};
      in_proc_n <= `PBSS_RST_STROBE_N;
      in_ctrl_n <= `PBSS_RST_STROBE_N;
      in_step_n <= `PBSS_RST_STROBE_N;
      in_ce_first_n <= `PBSS_RST_CE_FIRST_N;
      in_ce_second <= `PBSS_RST_CE_SECOND;
      in_ce_third_n <= `PBSS_RST_CE_THIRD_N;
      in_lanes_n <= `PBSS_RST_LANES_N;
      in_bwe_n <= `PBSS_RST_WRITE_N;
      in_gw_n <= `PBSS_RST_WRITE_N;
    end else begin
      in_addr <= ADDR_I;
      in_data <= DQ_I;
      in_proc_n <= PROCESSOR_ADDR_STROBE_N_I;
      in_ctrl_n <= CONTROLLER_ADDR_STROBE_N_I;
      in_step_n <= BURST_STEP_N_I;
      in_ce_first_n <= CHIP_SELECT_FIRST_N_I;
      in_ce_second <= CHIP_SELECT_SECOND_I;
      in_ce_third_n <= CHIP_SELECT_THIRD_N_I;
      in_lanes_n <= BYTE_LANE_WRITE_SELECT_N_I;
      in_bwe_n <= BYTE_WRITE_ENABLE_N_I;
      in_gw_n <= GLOBAL_WRITE_N_I;
    end
  end

  // ****************************************
  // Cycle decode
  // ****************************************
  reg active;
  wire selected;
  wire proc_take;
  wire ctrl_take;
  wire strobe;
  wire start;
  wire deselect;
  wire cont;
  wire issue;
  reg [LANES-1:0] lanes;

  assign selected = ~in_ce_first_n & in_ce_second & ~in_ce_third_n;
  assign proc_take = ~in_proc_n & ~in_ce_first_n;
  assign ctrl_take = ~in_ctrl_n & ~proc_take;
  assign strobe = proc_take | ctrl_take;
  assign start = strobe & selected & ~SLEEP_REQUEST_I;
  assign deselect = strobe & ~selected;
  // Burst beats need no new address
  assign cont = active & ~strobe & ~SLEEP_REQUEST_I;
  // Sleep blocks every array access
  assign issue = start | cont;

  always @* begin
    if (!in_gw_n) begin
      lanes = `PBSS_ALL_LANES;
    end else if (!in_bwe_n) begin
      lanes = ~in_lanes_n;
    end else begin
      lanes = `PBSS_NO_LANES;
    end
  end

  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      active <= 1'b0;
    end else if (start) begin
      active <= 1'b1;
    end else if (deselect) begin
      active <= 1'b0;
    end
  end

  // ****************************************
  // Address path
  // ****************************************
  reg [ADDR_W-3:0] addr_hi;
  wire [1:0] burst_low;
  wire [ADDR_W-1:0] eff_addr;

  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      addr_hi <= {(ADDR_W-2){1'b0}};
    end else if (start) begin
      addr_hi <= in_addr[ADDR_W-1:`PBSS_UPPER_LO];
    end
  end

  pbss_burst u_burst (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .load_i(start),
    .load_val_i(in_addr[`PBSS_LOW_HI:`PBSS_LOW_LO]),
    .step_i(cont & ~in_step_n),
    .interleaved_i(BURST_ORDER_INTERLEAVED_I),
    .low_o(burst_low)
  );

  // Upper bits fixed for the whole burst
  assign eff_addr = {start ? in_addr[ADDR_W-1:`PBSS_UPPER_LO] : addr_hi,
                     burst_low};

  // ****************************************
  // Array
  // ****************************************
  wire wr_go;
  wire rd_go;
  wire [LANES*LANE_W-1:0] mem_q;

  assign wr_go = issue & (|lanes);
  assign rd_go = issue & ~(|lanes);

  pbss_mem #(
    .ADDR_W(ADDR_W),
    .DEPTH(DEPTH),
    .LANES(LANES),
    .LANE_W(LANE_W)
  ) u_mem (
    .clk_i(CLK_I),
    .wr_en_i(wr_go),
    .wr_lanes_i(lanes),
    .rd_en_i(rd_go),
    .addr_i(eff_addr),
    .wdata_i(in_data),
    .rdata_o(mem_q)
  );

  // ****************************************
  // Output pipeline
  // ****************************************
  reg rd_pend;
  reg out_valid;
  reg first_mask;

  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      rd_pend <= 1'b0;
      out_valid <= 1'b0;
      first_mask <= 1'b0;
      DQ_O <= {LANES*LANE_W{1'b0}};
    end else begin
      rd_pend <= rd_go;
      out_valid <= rd_pend;
      first_mask <= start & ~active & ~(|lanes);
      if (rd_pend) begin
        DQ_O <= mem_q;
      end
    end
  end

  // Output enable and sleep gate the drive directly
  assign DQ_OE_O = out_valid & ~first_mask & ~OUTPUT_ENABLE_N_I &
                   ~SLEEP_REQUEST_I;

endmodule

`default_nettype wire
